/* verilog/pba_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
module pba_arbiter
	import pba_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] req_n,
	output logic [3:0] gnt_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic own_req,
	output logic own_gnt,
	output logic ext_req_n,
	input wire logic ext_gnt_n
);
	// protection bits carry no meaning here
	logic unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

	// word decode: 0 unmapped, 1 reserved, 2 arbiter, 3 status
	function automatic logic [1:0] addr_sel(input logic [7:0] a);
		logic [1:0] s;
		s = 2'h0;
		if (a[7:2] == PBA_OFS_RSVD[7:2]) s = 2'h1;
		if (a[7:2] == PBA_OFS_CFG[7:2]) s = 2'h2;
		if (a[7:2] == PBA_OFS_STAT[7:2]) s = 2'h3;
		return s;
	endfunction

	// byte-lane merge limited to the writable bits
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] m;
		m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & PBA_CFG_WMASK;
		return (old & ~m) | (nw & m);
	endfunction

	// one-hot vector for a requester index
	function automatic logic [PBA_NREQ-1:0] onehot(input logic [2:0] idx);
		return PBA_NREQ'(1) << idx;
	endfunction

	pba_state_type q; // registered state
	pba_state_type d; // next state

	logic [PBA_NREQ-1:0] req_raw; // active-high view of all requests
	logic [PBA_NREQ-1:0] excl; // suspect or broken requesters
	logic [PBA_NREQ-1:0] elig; // requests taking part in arbitration
	logic [PBA_NREQ-1:0] others; // eligible requests other than the owner
	logic pick_any; // someone can be granted
	logic [2:0] pick_win; // who would be granted
	logic ext_mode; // external arbiter selected
	logic bus_idle; // frame and irdy both high
	logic frame_fall; // frame seen going low this clock
	logic bm_cond; // broken-master count runs this clock
	logic bm_expire; // sixteenth idle clock without frame
	logic fair_expire; // fairness budget used up
	logic [7:0] cfg_fair; // fairness seed field
	logic [31:0] stat_word; // status register image

	assign ext_mode = q.cfg[PBA_EXT_BIT];
	assign cfg_fair = q.cfg[PBA_FAIR_LSB +: 8];
	assign bus_idle = frame_n & irdy_n;
	assign frame_fall = q.frame_prev & ~frame_n;
	assign req_raw = {~req_n, own_req};
	assign excl = q.suspect | q.broken;
	// disabled or broken requesters never reach the picker
	assign elig = req_raw & q.cfg[PBA_EN_LSB +: PBA_NREQ] & ~excl;
	assign others = elig & ~onehot(q.owner);
	assign bm_cond = q.cfg[PBA_BM_EN_BIT] & ~q.seen_frame & bus_idle;
	assign bm_expire = bm_cond & (q.bm_cnt == PBA_BM_LAST);
	// a zero seed never expires, so the owner keeps the bus until it lets go
	assign fair_expire = (cfg_fair != 8'h00) & q.armed & (|others) & (q.fair == 8'h00);

	// priority levels steer the picker
	pba_pick u_pick (
		.req(elig),
		.hi(q.cfg[PBA_PRIO_LSB +: PBA_NREQ]),
		.last(q.last),
		.any(pick_any),
		.win(pick_win)
	);

	// status image: owner, grant, exclusion sets, fairness count
	always_comb begin
		stat_word = 32'h0;
		stat_word[PBA_STAT_OWNER_LSB +: 3] = q.owner;
		stat_word[PBA_STAT_GRANTED_BIT] = (q.st == PBA_ARB_GRANT);
		stat_word[PBA_STAT_SUSPECT_LSB +: PBA_NREQ] = q.suspect;
		stat_word[PBA_STAT_BROKEN_LSB +: PBA_NREQ] = q.broken;
		stat_word[PBA_STAT_FAIR_LSB +: 8] = q.fair;
		stat_word[PBA_STAT_ARMED_BIT] = q.armed;
		stat_word[PBA_STAT_EXT_BIT] = (q.st == PBA_ARB_EXT);
	end

	// all next-state logic: bus slave, arbiter, pin outputs
	always_comb begin
		d = q;
		d.frame_prev = frame_n;
		// write address and data are taken independently, in any order
		if (s_axi_awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_have = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		// commit once both halves are held and no response is pending
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = PBA_RESP_OKAY;
			case (addr_sel(q.awaddr))
				2'h2: begin
					d.cfg = merge(q.cfg, q.wdata, q.wstrb);
				end
				2'h1, 2'h3: begin
					d.bresp = PBA_RESP_OKAY; // read-only words ignore writes
				end
				default: begin
					d.bresp = PBA_RESP_SLVERR;
				end
			endcase
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;
		// reads answer one clock after the address is taken
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = PBA_RESP_OKAY;
			case (addr_sel(s_axi_araddr))
				2'h1: d.rdata = 32'h0;
				2'h2: d.rdata = q.cfg;
				2'h3: d.rdata = stat_word;
				default: begin
					d.rdata = 32'h0;
					d.rresp = PBA_RESP_SLVERR;
				end
			endcase
		end
		d.arready = !d.rvalid;

		// a released request turns a suspect into a broken master, cleared only by a refresh
		d.broken = q.broken | (q.suspect & ~req_raw);
		d.suspect = q.suspect & req_raw;
		// refresh once every other usable master has had the bus
		if (q.cfg[PBA_REFRESH_BIT] && (|excl)
			&& ((q.served | excl | ~q.cfg[PBA_EN_LSB +: PBA_NREQ]) == {PBA_NREQ{1'b1}})) begin
			d.broken = '0;
			d.suspect = '0;
			d.served = '0;
		end

		// arbiter sequence
		case (q.st)
			PBA_ARB_IDLE: begin
				if (ext_mode) begin
					d.st = PBA_ARB_EXT;
				end else if (pick_any) begin
					d.st = PBA_ARB_GRANT;
					d.owner = pick_win;
					d.last = pick_win;
					d.fair = cfg_fair;
					d.armed = 1'b0;
					d.seen_frame = 1'b0;
					d.bm_cnt = 4'h0;
					d.tog = 2'h0;
					d.served = d.served | onehot(pick_win);
				end
			end
			PBA_ARB_GRANT: begin
				if (ext_mode) begin
					d.st = PBA_ARB_EXT;
				end else begin
					// first frame fall after the grant arms fairness and starts the toggle delay
					if (frame_fall && !q.seen_frame) begin
						d.armed = 1'b1;
						d.seen_frame = 1'b1;
						d.tog = q.cfg[PBA_TOGGLE_BIT] ? PBA_TOG_DELAY : 2'h0;
					end else if (q.tog != 2'h0) begin
						d.tog = q.tog - 2'h1;
					end
					// broken-master watch only runs while the bus sits idle
					if (bm_cond && !bm_expire) begin
						d.bm_cnt = q.bm_cnt + 4'h1;
					end else begin
						d.bm_cnt = 4'h0;
					end
					// fairness only burns while someone else is waiting
					if (q.armed && (|others) && (q.fair != 8'h00)) begin
						d.fair = q.fair - 8'h01;
					end
					if (bm_expire && (q.owner != 3'h0)) begin
						// the bridge's own master is never marked, it has no way to be refreshed by software alone
						d.suspect = d.suspect | onehot(q.owner);
						d.served = '0;
					end
					if (!elig[q.owner] || bm_expire || fair_expire) begin
						d.st = PBA_ARB_IDLE;
					end
				end
			end
			PBA_ARB_EXT: begin
				if (!ext_mode) begin
					d.st = PBA_ARB_IDLE;
				end
			end
			default: begin
				d.st = PBA_ARB_IDLE;
			end
		endcase

		// pin outputs follow the next state so they leave with it
		for (int k = 1; k <= PBA_NEXT; k++) begin
			d.gnt_n[k-1] = !((d.st == PBA_ARB_GRANT) && (d.owner == 3'(k)) && (q.tog != 2'h1));
		end
		if (d.st == PBA_ARB_EXT) begin
			d.gnt_n = '1;
			d.own_gnt = !ext_gnt_n;
			d.ext_req_n = !own_req;
		end else begin
			d.own_gnt = (d.st == PBA_ARB_GRANT) && (d.owner == 3'h0);
			d.ext_req_n = 1'b1;
		end
	end

	// single state register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= PBA_STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign gnt_n = q.gnt_n;
	assign own_gnt = q.own_gnt;
	assign ext_req_n = q.ext_req_n;

	// a new grant only goes to a requester enabled when it was chosen; a write in that clock must not fire it
	AST_GRANT_ENABLED: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == PBA_ARB_IDLE && !ext_mode && pick_any)
		|=> (($past(q.cfg[PBA_EN_LSB +: PBA_NREQ]) & onehot(q.owner)) != '0))
		else $error("grant given to a disabled requester");

	// external mode passes the own request straight out
	AST_EXT_REQ_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
		(ext_mode && q.st == PBA_ARB_EXT) |=> (q.ext_req_n == !$past(own_req)))
		else $error("own request not forwarded in external mode");

	// count steps by one while the bus idles without frame
	AST_BM_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == PBA_ARB_GRANT && !ext_mode && bm_cond && !bm_expire) |=> (q.bm_cnt == $past(q.bm_cnt) + 4'h1))
		else $error("broken-master count did not advance");

	// sixteenth idle clock removes the grant and every grant line
	AST_BM_EXPIRE: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == PBA_ARB_GRANT && !ext_mode && bm_expire) |=> (q.st == PBA_ARB_IDLE && q.gnt_n == 4'hF))
		else $error("grant kept after broken-master expiry");

	// without refresh a broken mark never goes away
	AST_BROKEN_STICKS: assert property (@(posedge aclk) disable iff (!aresetn)
		!q.cfg[PBA_REFRESH_BIT] |=> ((q.broken & $past(q.broken)) == $past(q.broken)))
		else $error("broken master cleared without refresh");

	// a fresh grant starts with the configured budget, disarmed
	AST_FAIR_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == PBA_ARB_IDLE && !ext_mode && pick_any) |=> (q.fair == $past(cfg_fair) && !q.armed))
		else $error("fairness counter not reloaded on grant");

	// first frame fall of a grant arms the counter
	AST_FAIR_ARM: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == PBA_ARB_GRANT && !ext_mode && frame_fall && !q.seen_frame) |=> q.armed)
		else $error("fairness counter not armed by frame fall");

	// zero seed keeps the owner granted while it still requests
	AST_FAIR_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == PBA_ARB_GRANT && !ext_mode && cfg_fair == 8'h00 && elig[q.owner] && !bm_expire)
		|=> (q.st == PBA_ARB_GRANT))
		else $error("grant removed with zero fairness seed");

	// grant line drops in the third clock after the frame fall, unless the bus has since moved to another owner
	AST_TOGGLE: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == PBA_ARB_GRANT && !ext_mode && q.cfg[PBA_TOGGLE_BIT] && frame_fall && !q.seen_frame)
		|-> ##3 (q.gnt_n == 4'hF || q.owner != $past(q.owner, 3)))
		else $error("grant toggle missing or mistimed");

	// a high-level request always beats a low-level one, judged by the levels of the choosing clock
	AST_PRIO: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == PBA_ARB_IDLE && !ext_mode && |(elig & q.cfg[PBA_PRIO_LSB +: PBA_NREQ]))
		|=> (($past(q.cfg[PBA_PRIO_LSB +: PBA_NREQ]) & onehot(q.owner)) != '0))
		else $error("low priority requester won over high");

	// external mode never grants a master
	AST_EXT_NO_GNT: assert property (@(posedge aclk) disable iff (!aresetn)
		ext_mode |=> (q.gnt_n == 4'hF))
		else $error("master granted while external arbiter selected");
endmodule
`default_nettype wire

/* verilog/pba_pkg.sv */
package pba_pkg;
	// requesters: index 0 is the bridge itself, 1 to 4 the external masters
	localparam int PBA_NREQ = 5;
	localparam int PBA_NEXT = 4;
	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] PBA_OFS_RSVD = 8'h44;
	localparam logic [7:0] PBA_OFS_CFG = 8'h48;
	localparam logic [7:0] PBA_OFS_STAT = 8'h80;
	// field positions in the arbiter register
	localparam int PBA_EN_LSB = 0;
	localparam int PBA_EXT_BIT = 9;
	localparam int PBA_BM_EN_BIT = 10;
	localparam int PBA_REFRESH_BIT = 11;
	localparam int PBA_FAIR_LSB = 12;
	localparam int PBA_TOGGLE_BIT = 20;
	localparam int PBA_PRIO_LSB = 22;
	// field reset values
	localparam logic [4:0] PBA_EN_RST = 5'h1F;
	localparam logic [7:0] PBA_FAIR_RST = 8'h08;
	localparam logic [4:0] PBA_PRIO_RST = 5'h01;
	localparam logic [31:0] PBA_CFG_RST = {27'h0, PBA_EN_RST} | ({24'h0, PBA_FAIR_RST} << PBA_FAIR_LSB)
		| ({27'h0, PBA_PRIO_RST} << PBA_PRIO_LSB);
	// writable bits; reserved bits 8:5, 21 and 31:27 stay zero
	localparam logic [31:0] PBA_CFG_WMASK = 32'h07DF_FE1F;
	// status register field positions
	localparam int PBA_STAT_OWNER_LSB = 0;
	localparam int PBA_STAT_GRANTED_BIT = 3;
	localparam int PBA_STAT_SUSPECT_LSB = 4;
	localparam int PBA_STAT_BROKEN_LSB = 9;
	localparam int PBA_STAT_FAIR_LSB = 16;
	localparam int PBA_STAT_ARMED_BIT = 24;
	localparam int PBA_STAT_EXT_BIT = 25;
	// timing counts in bus clocks
	localparam int PBA_BM_CYCLES = 16;
	localparam logic [3:0] PBA_BM_LAST = 4'(PBA_BM_CYCLES - 1);
	localparam logic [1:0] PBA_TOG_DELAY = 2'h2;
	// axi responses
	localparam logic [1:0] PBA_RESP_OKAY = 2'h0;
	localparam logic [1:0] PBA_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PBA_ARB_IDLE = 2'b00,
		PBA_ARB_GRANT = 2'b01,
		PBA_ARB_EXT = 2'b10
	} pba_st_type;

	typedef struct packed {
		pba_st_type st;
		logic [2:0] owner;
		logic [2:0] last;
		logic [7:0] fair;
		logic armed;
		logic seen_frame;
		logic [3:0] bm_cnt;
		logic [1:0] tog;
		logic frame_prev;
		logic [PBA_NREQ-1:0] suspect;
		logic [PBA_NREQ-1:0] broken;
		logic [PBA_NREQ-1:0] served;
		logic [31:0] cfg;
		logic [PBA_NEXT-1:0] gnt_n;
		logic own_gnt;
		logic ext_req_n;
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pba_state_type;

	localparam pba_state_type PBA_STATE_RST = '{st: PBA_ARB_IDLE, cfg: PBA_CFG_RST, gnt_n: 4'hF,
		ext_req_n: 1'b1, frame_prev: 1'b1, default: '0};
endpackage

/* verilog/pba_pick.sv */
`timescale 1ns/100ps
`default_nettype none
// two-level round-robin choice: high-priority requesters first, then the rest
module pba_pick
	import pba_pkg::*;
(
	input wire logic [PBA_NREQ-1:0] req,
	input wire logic [PBA_NREQ-1:0] hi,
	input wire logic [2:0] last,
	output logic any,
	output logic [2:0] win
);
	// first set bit after the last winner, wrapping around
	function automatic logic [2:0] rr(input logic [PBA_NREQ-1:0] r, input logic [2:0] l);
		logic [2:0] w;
		logic hit;
		int k;
		w = l;
		hit = 1'b0;
		for (int i = 1; i <= PBA_NREQ; i++) begin
			k = (int'(l) + i) % PBA_NREQ;
			if (!hit && r[k]) begin
				w = 3'(k);
				hit = 1'b1;
			end
		end
		return w;
	endfunction

	logic [PBA_NREQ-1:0] hi_req; // requesters at high level

	// low level only competes when no high-level request is up
	always_comb begin
		hi_req = req & hi;
		any = |req;
		win = (|hi_req) ? rr(hi_req, last) : rr(req, last);
	end
endmodule
`default_nettype wire

/* dv/pba_pci_masters.sv */
`timescale 1ns/100ps
`default_nettype none
// four outside bus masters sharing one frame; each runs one short frame per fresh grant
module pba_pci_masters (
	input wire logic clk,
	input wire logic [3:0] gnt_n,
	input wire logic [3:0] want,
	input wire logic [3:0] mute,
	output logic [3:0] req_n,
	output logic frame_n,
	output logic irdy_n
);
	localparam logic [3:0] FLEN = 4'h6; // frame clocks plus the last data phase
	logic [3:0] cnt_q = 4'h0; // clocks left of the running transaction
	logic [3:0] gprev_q = 4'hF; // grants seen at the previous edge
	// start only on a grant that is new and only on an idle bus, so no two masters collide;
	// a muted master never starts, which is how a broken one looks from the arbiter
	always_ff @(posedge clk) begin
		gprev_q <= gnt_n;
		if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end else if ((|(gprev_q & ~gnt_n & want & ~mute)) && frame_n && irdy_n) begin
			cnt_q <= FLEN;
		end
	end
	// requests are plain levels from the bench
	assign req_n = ~want;
	// released lines float back high through the bus pull-ups
	assign frame_n = (cnt_q < 4'h2);
	assign irdy_n = (cnt_q == 4'h0);
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pba_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic own_req = 1'b0;
	logic ext_gnt_n = 1'b1;
	logic [3:0] want = 4'h0; // request level per outside master
	logic [3:0] mute = 4'h0; // masters that never start a frame
	wire logic awready, wready, bvalid, arready, rvalid, frame_n, irdy_n, own_gnt, ext_req_n;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [3:0] req_n, gnt_n;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic [1:0] rs;
	int n;
	int d1;

	pba_arbiter i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .req_n(req_n), .gnt_n(gnt_n), .frame_n(frame_n), .irdy_n(irdy_n),
		.own_req(own_req), .own_gnt(own_gnt), .ext_req_n(ext_req_n), .ext_gnt_n(ext_gnt_n));

	pba_pci_masters i_masters (.clk(aclk), .gnt_n(gnt_n), .want(want), .mute(mute), .req_n(req_n),
		.frame_n(frame_n), .irdy_n(irdy_n));

	// 40 MHz bus clock
	always #12.5 aclk = ~aclk;

	// watchdog: a hang counts as a mismatch
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			end_sim();
		end
	end

	task automatic end_sim();
		if (num_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge aclk);
	endtask

	// address and data offered together, each dropped at its own handshake
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge aclk);
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		cmp("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	function automatic logic [31:0] cfg_of(input logic [4:0] en, input logic [7:0] fair, input logic [31:0] x);
		return {27'h0, en} | ({24'h0, fair} << PBA_FAIR_LSB) | ({27'h0, PBA_PRIO_RST} << PBA_PRIO_LSB) | x;
	endfunction

	task automatic set_cfg(input logic [31:0] v);
		axi_wr(PBA_OFS_CFG, v, PBA_RESP_OKAY);
	endtask

	// clocks until grant m is seen, capped at lim
	task automatic wait_low(input int m, input int lim, output int k);
		k = 0;
		@(posedge aclk);
		while (gnt_n[m] !== 1'b0 && k < lim) begin
			k++;
			@(posedge aclk);
		end
	endtask

	// clocks that grant m stays low, capped so a stuck grant ends the wait
	task automatic hold_len(input int m, output int k);
		k = 0;
		while (gnt_n[m] === 1'b0 && k < 60) begin
			k++;
			@(posedge aclk);
		end
	endtask

	task automatic hold_any(output int k);
		int m;
		m = 0;
		k = 0;
		@(posedge aclk);
		while (gnt_n === 4'hF && k < 50) begin
			k++;
			@(posedge aclk);
		end
		for (int i = 0; i < 4; i++) if (gnt_n[i] === 1'b0) m = i;
		hold_len(m, k);
	endtask

	// drop every request and let the bus settle
	task automatic quiet();
		want <= 4'h0;
		mute <= 4'h0;
		own_req <= 1'b0;
		idle(8);
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		idle(2);
		// register reset value, writable bits and refused addresses
		axi_rd(PBA_OFS_CFG, rd, rs);
		cmp("cfg reset", PBA_CFG_RST, rd);
		axi_rd(PBA_OFS_RSVD, rd, rs);
		cmp("rsvd read", 32'h0, rd);
		cmp("rsvd resp", {30'h0, PBA_RESP_OKAY}, {30'h0, rs});
		axi_rd(8'h10, rd, rs);
		cmp("unmapped resp", {30'h0, PBA_RESP_SLVERR}, {30'h0, rs});
		axi_wr(8'h10, 32'hFFFF_FFFF, PBA_RESP_SLVERR);
		set_cfg(32'hFFFF_FFFF);
		axi_rd(PBA_OFS_CFG, rd, rs);
		cmp("cfg all ones", PBA_CFG_WMASK, rd);
		// a cleared enable keeps master 2 off the bus while master 1 still wins
		set_cfg(cfg_of(5'h1B, 8'h08, 32'h0));
		want <= 4'h2;
		wait_low(1, 30, n);
		cmp("disabled master wait", 32'd30, n);
		want <= 4'h3;
		wait_low(0, 30, n);
		cmp("enabled master wait", 32'h1, 32'(n < 5));
		// the single high-priority requester wins a simultaneous start
		for (int i = 0; i < 2; i++) begin
			quiet();
			set_cfg(cfg_of(5'h1F, 8'h08, 32'h1 << (24 - i)));
			want <= 4'h3;
			wait_low(1 - i, 10, n);
			cmp("high priority wait", 32'h1, 32'(n < 10));
			cmp("low priority held off", 32'h1, {31'h0, gnt_n[i]});
		end
		// fairness seed 4: two tenures alike and bounded
		quiet();
		set_cfg(cfg_of(5'h1F, 8'h04, 32'h0));
		want <= 4'h3;
		hold_any(d1);
		hold_any(n);
		cmp("fair hold repeat", d1, n);
		cmp("fair hold bound", 32'h1, 32'((d1 > 4) && (d1 < 11)));
		// no frame means the count is never armed
		quiet();
		mute <= 4'h3;
		want <= 4'h3;
		hold_any(n);
		cmp("unarmed hold", 32'd60, n);
		// seed zero holds through a frame with a rival pending, no toggle
		quiet();
		set_cfg(cfg_of(5'h1F, 8'h00, 32'h0));
		want <= 4'h3;
		hold_any(n);
		cmp("zero seed hold", 32'd60, n);
		// toggle: grant dropped one clock, three after the frame start
		quiet();
		set_cfg(cfg_of(5'h1F, 8'h00, 32'h1 << PBA_TOGGLE_BIT));
		want <= 4'h1;
		n = 0;
		do @(posedge aclk); while (frame_n !== 1'b0);
		do begin
			@(posedge aclk);
			n++;
		end while (gnt_n[0] !== 1'b1 && n < 10);
		cmp("toggle delay", 32'd3, n);
		@(posedge aclk);
		cmp("toggle width", 32'h0, {31'h0, gnt_n[0]});
		// broken master: timeout, permanent exclusion, then refresh
		quiet();
		set_cfg(cfg_of(5'h0A, 8'h00, 32'h1 << PBA_BM_EN_BIT));
		mute <= 4'h4;
		want <= 4'h4;
		wait_low(2, 10, n);
		hold_len(2, n);
		cmp("broken timeout", PBA_BM_CYCLES, n);
		want <= 4'h0;
		idle(3);
		want <= 4'h4;
		wait_low(2, 40, n);
		cmp("broken stays out", 32'd40, n);
		axi_rd(PBA_OFS_STAT, rd, rs);
		cmp("broken status", 32'h1, {31'h0, rd[PBA_STAT_BROKEN_LSB + 3]});
		set_cfg(cfg_of(5'h0A, 8'h00, 32'h3 << PBA_BM_EN_BIT));
		want <= 4'h5;
		wait_low(0, 10, n);
		want <= 4'h4;
		wait_low(2, 30, n);
		cmp("refreshed master wait", 32'h1, 32'(n < 30));
		// own request at its reset high level beats two waiting masters
		quiet();
		set_cfg(cfg_of(5'h1F, 8'h08, 32'h0));
		own_req <= 1'b1;
		want <= 4'h3;
		idle(3);
		cmp("own grant", 32'h1, {31'h0, own_gnt});
		cmp("own grant excludes masters", 32'hF, {28'h0, gnt_n});
		// outside arbiter: no grants, own request relayed both ways
		quiet();
		set_cfg(cfg_of(5'h1F, 8'h08, 32'h1 << PBA_EXT_BIT));
		want <= 4'hF;
		own_req <= 1'b1;
		idle(20);
		cmp("ext mode grants", 32'hF, {28'h0, gnt_n});
		cmp("ext request out", 32'h0, {31'h0, ext_req_n});
		ext_gnt_n <= 1'b0;
		idle(3);
		cmp("ext grant relay", 32'h1, {31'h0, own_gnt});
		end_sim();
	end
endmodule
`default_nettype wire
